// ==== rtl/tcf_top.sv ====
// Sensor configuration register, smoothing filter and alert status flags
//
// Behaviour
// RULE1 - Status bit 3 is one when selected temperature exceeds fourth limit.
// RULE2 - Status bits 2..0 flag third, second, first limits exceeded strictly.
// RULE3 - Each alert compares hot or cold junction per software selection.
// RULE4 - Config bits 6..4 select type K,J,T,N,S,E,B,R for codes 0..7.
// RULE5 - Type selects its own correction coefficient set.
// RULE6 - Filter output depends only on newest sample and previous output.
// RULE7 - Output is k*x plus (1-k)*previous, k=2/(2^n+1), into difference register.
// RULE8 - Coefficient n in bits 2..0; zero means filter off.
// RULE9 - Any config write restarts the filter history.
// RULE10 - Config bits 7 and 3 read as zero.
// RULE11 - With filtering on, hot-junction alerts use filtered data.
// RULE12 - Power-on clears config to type K, filter off, empty history.
`timescale 1ns/10ps
`default_nettype none
module tcf_top
	import tcf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register port from the serial interface logic
	input wire logic cfg_wr_i,
	input wire logic [7:0] cfg_wdata_i,
	output logic [7:0] cfg_rdata_o,
	output logic [7:0] status_alert_o,
	// Conversion samples
	input wire logic hot_vld_i,
	input wire logic signed [TCF_TEMP_W-1:0] hot_i,
	input wire logic signed [TCF_TEMP_W-1:0] cold_i,
	// Alert limits and per-alert source select (1 = cold junction)
	input wire logic signed [TCF_TEMP_W-1:0] first_alert_limit_i,
	input wire logic signed [TCF_TEMP_W-1:0] second_alert_limit_i,
	input wire logic signed [TCF_TEMP_W-1:0] third_alert_limit_i,
	input wire logic signed [TCF_TEMP_W-1:0] fourth_alert_limit_i,
	input wire logic [TCF_NUM_ALERTS-1:0] alert_src_cold_i,
	// Conversion results
	output logic signed [TCF_TEMP_W-1:0] delta_temp_o,
	output logic [2:0] tc_type_o,
	output logic [7:0] corr_coef_set_o
);
	// --------------------------------------------------------------
	// Sensor configuration register
	// --------------------------------------------------------------
	logic [7:0] cfg_ff, nxt_cfg;
	logic [2:0] coef_n;
	logic clear_ff, nxt_clear;

	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_clear = 1'b0;
		if (cfg_wr_i) begin
			nxt_cfg = cfg_wdata_i & TCF_CFG_IMPL_MASK; // [RULE10]
			nxt_clear = 1'b1; // [RULE9]
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_ff <= TCF_CFG_RESET; // [RULE12]
			clear_ff <= 1'b0;
		end else begin
			cfg_ff <= nxt_cfg;
			clear_ff <= nxt_clear;
		end
	end

	assign coef_n = cfg_ff[TCF_CFG_FILT_MSB:TCF_CFG_FILT_LSB];

	// --------------------------------------------------------------
	// Type decode and correction set
	// --------------------------------------------------------------
	// Coefficient tables live in the arithmetic; only the set index is made here
	function automatic logic [7:0] tcf_coef_set(input logic [2:0] code);
		tcf_type_t t;
		logic [7:0] s;
		t = tcf_type_t'(code);
		s = 8'h00;
		unique case (t)
			TCF_TYPE_K: s = 8'h01;
			TCF_TYPE_J: s = 8'h02;
			TCF_TYPE_T: s = 8'h04;
			TCF_TYPE_N: s = 8'h08;
			TCF_TYPE_S: s = 8'h10;
			TCF_TYPE_E: s = 8'h20;
			TCF_TYPE_B: s = 8'h40;
			TCF_TYPE_R: s = 8'h80;
		endcase
		return s;
	endfunction : tcf_coef_set

	logic [2:0] type_ff, nxt_type;
	logic [7:0] coef_ff, nxt_coef;
	logic [7:0] rdata_ff, nxt_rdata;

	always_comb begin
		nxt_type = nxt_cfg[TCF_CFG_TYPE_MSB:TCF_CFG_TYPE_LSB]; // [RULE4]
		nxt_coef = tcf_coef_set(nxt_type); // [RULE5]
		nxt_rdata = nxt_cfg & TCF_CFG_IMPL_MASK; // [RULE10]
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			type_ff <= 3'h0;
			coef_ff <= 8'h01;
			rdata_ff <= TCF_CFG_RESET;
		end else begin
			type_ff <= nxt_type;
			coef_ff <= nxt_coef;
			rdata_ff <= nxt_rdata;
		end
	end

	// --------------------------------------------------------------
	// Smoothing filter
	// --------------------------------------------------------------
	logic filt_vld;
	logic signed [TCF_TEMP_W-1:0] filt_out;

	tcf_ema u_ema (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.clear_i(clear_ff),
		.sample_vld_i(hot_vld_i),
		.sample_i(hot_i),
		.coef_n_i(coef_n),
		.out_vld_o(filt_vld),
		.out_o(filt_out)
	);

	logic signed [TCF_TEMP_W-1:0] delta_ff, nxt_delta;

	always_comb begin
		nxt_delta = delta_ff;
		if (filt_vld) begin
			nxt_delta = filt_out; // [RULE7]
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			delta_ff <= '0;
		end else begin
			delta_ff <= nxt_delta;
		end
	end

	// --------------------------------------------------------------
	// Alert comparisons
	// --------------------------------------------------------------
	// Hot-side value is the filter output, which equals the raw sample when off
	logic signed [TCF_TEMP_W-1:0] limit [TCF_NUM_ALERTS];
	logic [TCF_NUM_ALERTS-1:0] alert_ff, nxt_alert;

	assign limit[0] = first_alert_limit_i;
	assign limit[1] = second_alert_limit_i;
	assign limit[2] = third_alert_limit_i;
	assign limit[3] = fourth_alert_limit_i;

	always_comb begin
		for (int i = 0; i < TCF_NUM_ALERTS; i++) begin
			// Selected temperature strictly above its limit
			nxt_alert[i] = (alert_src_cold_i[i] ? cold_i : nxt_delta) > limit[i]; // [RULE1] [RULE2] [RULE3] [RULE11]
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			alert_ff <= '0;
		end else begin
			alert_ff <= nxt_alert;
		end
	end

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	assign cfg_rdata_o = rdata_ff;
	assign status_alert_o = {4'h0, alert_ff};
	assign delta_temp_o = delta_ff;
	assign tc_type_o = type_ff;
	assign corr_coef_set_o = coef_ff;


	// --------------------------------------------------------------
	// Rule checks
	// --------------------------------------------------------------
	// Flags are judged one cycle late, against the inputs of the cycle that set them
	a_alert4_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE1]
		##1 status_alert_o[3] == (($past(alert_src_cold_i[3]) ? $past(cold_i)
			: delta_temp_o) > $past(fourth_alert_limit_i)))
		else $error("fourth alert flag wrong");
	a_alert3_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE2] [RULE3]
		##1 status_alert_o[2] == (($past(alert_src_cold_i[2]) ? $past(cold_i)
			: delta_temp_o) > $past(third_alert_limit_i)))
		else $error("third alert flag wrong");
	a_alert2_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE2] [RULE11]
		##1 status_alert_o[1] == (($past(alert_src_cold_i[1]) ? $past(cold_i)
			: delta_temp_o) > $past(second_alert_limit_i)))
		else $error("second alert flag wrong");
	a_alert1_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE2] [RULE3]
		##1 status_alert_o[0] == (($past(alert_src_cold_i[0]) ? $past(cold_i)
			: delta_temp_o) > $past(first_alert_limit_i)))
		else $error("first alert flag wrong");
	a_cfg_read_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE10]
		cfg_rdata_o[7] == 1'b0 && cfg_rdata_o[3] == 1'b0)
		else $error("unimplemented config bit reads one");
	a_cfg_write_back: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE10]
		cfg_wr_i |=> cfg_rdata_o == ($past(cfg_wdata_i) & TCF_CFG_IMPL_MASK))
		else $error("config write not stored");
	a_type_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE4] [RULE5]
		cfg_wr_i |=> tc_type_o == $past(cfg_wdata_i[6:4])
			&& corr_coef_set_o == (8'h01 << $past(cfg_wdata_i[6:4])))
		else $error("type decode wrong");
	a_cfg_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE4] [RULE5]
		!cfg_wr_i |=> $stable(cfg_rdata_o) && $stable(tc_type_o)
			&& $stable(corr_coef_set_o))
		else $error("configuration moved without a write");
	a_coef_onehot: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE5]
		$onehot(corr_coef_set_o))
		else $error("correction set not one-hot");
	a_delta_update: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE7] [RULE8]
		hot_vld_i && !cfg_wr_i && !clear_ff && coef_n == TCF_FILT_OFF
			|=> ##1 delta_temp_o == $past(hot_i, 2))
		else $error("difference register not updated");
	a_status_high_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE2]
		status_alert_o[7:4] == 4'h0)
		else $error("unowned status bits driven");
	a_filter_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE6]
		!filt_vld |=> delta_temp_o == $past(delta_temp_o))
		else $error("difference register moved without a sample");
	a_sample_taken: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE6]
		hot_vld_i && !clear_ff |=> filt_vld)
		else $error("accepted sample produced no filter output");
	a_vld_needs_sample: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE6]
		!hot_vld_i |=> !filt_vld)
		else $error("filter output without a sample");
	a_clear_on_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE9]
		cfg_wr_i |=> clear_ff)
		else $error("config write did not clear the filter");
	a_clear_only_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE9]
		!cfg_wr_i |=> !clear_ff)
		else $error("filter cleared without a write");
	a_sample_dropped: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE9]
		clear_ff && hot_vld_i |=> !filt_vld)
		else $error("sample in the clear cycle was used");
	a_first_after_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE9]
		clear_ff ##1 (hot_vld_i && !clear_ff) |=> ##1 delta_temp_o == $past(hot_i, 2))
		else $error("first sample after a write not passed raw");
endmodule : tcf_top
`default_nettype wire

// ==== shared/tcf_pkg.sv ====
// Shared constants and types for the thermocouple filter and configuration block
package tcf_pkg;
	// --------------------------------------------------------------
	// Widths
	// --------------------------------------------------------------
	localparam int TCF_TEMP_W = 16;
	localparam int TCF_ACC_W = 24;
	localparam int TCF_FRAC_W = 8;
	localparam int TCF_NUM_ALERTS = 4;

	// --------------------------------------------------------------
	// Sensor configuration register fields
	// --------------------------------------------------------------
	localparam int TCF_CFG_TYPE_LSB = 4;
	localparam int TCF_CFG_TYPE_MSB = 6;
	localparam int TCF_CFG_FILT_LSB = 0;
	localparam int TCF_CFG_FILT_MSB = 2;
	localparam logic [7:0] TCF_CFG_RESET = 8'h00;
	localparam logic [7:0] TCF_CFG_IMPL_MASK = 8'h77;
	localparam logic [2:0] TCF_FILT_OFF = 3'h0;

	// --------------------------------------------------------------
	// Status register fields
	// --------------------------------------------------------------
	localparam int TCF_STAT_ALERT_LSB = 0;
	localparam logic [7:0] TCF_STAT_RESET = 8'h00;

	typedef enum logic [2:0] {
		TCF_TYPE_K = 3'h0,
		TCF_TYPE_J = 3'h1,
		TCF_TYPE_T = 3'h2,
		TCF_TYPE_N = 3'h3,
		TCF_TYPE_S = 3'h4,
		TCF_TYPE_E = 3'h5,
		TCF_TYPE_B = 3'h6,
		TCF_TYPE_R = 3'h7
	} tcf_type_t;

	typedef enum logic [0:0] {
		TCF_FST_EMPTY = 1'h0,
		TCF_FST_RUN = 1'h1
	} tcf_fstate_t;
endpackage : tcf_pkg

// ==== rtl/tcf_ema.sv ====
// First-order recursive smoothing stage for hot-junction samples
`timescale 1ns/10ps
`default_nettype none
module tcf_ema
	import tcf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic clear_i,
	input wire logic sample_vld_i,
	input wire logic signed [TCF_TEMP_W-1:0] sample_i,
	input wire logic [2:0] coef_n_i,
	output logic out_vld_o,
	output logic signed [TCF_TEMP_W-1:0] out_o
);
	// --------------------------------------------------------------
	// Filter state
	// --------------------------------------------------------------
	// Wide fractional state keeps the output from sticking more than one unit short of the input
	tcf_fstate_t state_ff, nxt_state;
	logic signed [TCF_ACC_W-1:0] y_ff, nxt_y;
	logic out_vld_ff, nxt_out_vld;
	logic signed [TCF_ACC_W-1:0] x_ext;
	logic signed [TCF_ACC_W+10:0] prod;
	logic [9:0] den;

	always_comb begin
		x_ext = TCF_ACC_W'(sample_i) <<< TCF_FRAC_W;
		den = 10'((11'h001 << coef_n_i) + 11'h001);
		nxt_state = state_ff;
		nxt_y = y_ff;
		nxt_out_vld = 1'b0;
		// y += 2*(x-y)/(2^n+1), i.e. k*x + (1-k)*y with k = 2/(2^n+1)
		prod = (TCF_ACC_W+11)'(x_ext - y_ff) * (TCF_ACC_W+11)'(2);
		if (clear_i) begin
			nxt_state = TCF_FST_EMPTY; // [RULE9]
		end else if (sample_vld_i) begin
			nxt_out_vld = 1'b1;
			if (coef_n_i == TCF_FILT_OFF || state_ff == TCF_FST_EMPTY) begin
				nxt_y = x_ext; // [RULE8]
			end else begin
				nxt_y = TCF_ACC_W'(y_ff + TCF_ACC_W'(prod / $signed({1'b0, den}))); // [RULE6] [RULE7]
			end
			nxt_state = TCF_FST_RUN;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= TCF_FST_EMPTY; // [RULE12]
			y_ff <= '0;
			out_vld_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			y_ff <= nxt_y;
			out_vld_ff <= nxt_out_vld;
		end
	end

	assign out_vld_o = out_vld_ff;
	assign out_o = TCF_TEMP_W'(y_ff >>> TCF_FRAC_W);

	a_filter_off_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE8]
		sample_vld_i && !clear_i && coef_n_i == TCF_FILT_OFF |=> out_o == $past(sample_i))
		else $error("unfiltered sample not passed through");
	a_clear_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE9]
		clear_i ##1 (sample_vld_i && !clear_i) |=> out_o == $past(sample_i))
		else $error("filter history survived a config write");
endmodule : tcf_ema
`default_nettype wire

// ==== bench/tcf_host.sv ====
// Host model that writes the sensor configuration register
`timescale 1ns/10ps
`default_nettype none
module tcf_host (
	input wire logic clk_i,
	output logic cfg_wr_o,
	output logic [7:0] cfg_wdata_o
);
	initial begin
		cfg_wr_o = 1'b0;
		cfg_wdata_o = 8'h00;
	end

	task automatic write_cfg(input logic [7:0] d);
		@(negedge clk_i);
		cfg_wr_o = 1'b1;
		cfg_wdata_o = d;
		@(negedge clk_i);
		cfg_wr_o = 1'b0;
		// Data is not held after the strobe; inverse exposes late sampling
		cfg_wdata_o = ~d;
		// Returns on the falling edge that drops the strobe, inside the clear cycle, which ends at the next rising edge
	endtask : write_cfg
endmodule : tcf_host
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking testbench for the configuration, filter and alert block
`timescale 1ns/10ps
`default_nettype none
module tb
	import tcf_pkg::*;
;
	logic clk_i, rst_n_i, hot_vld_i, cfg_wr_i;
	logic [7:0] cfg_wdata_i, cfg_rdata_o, status_alert_o, corr_coef_set_o, d;
	logic signed [TCF_TEMP_W-1:0] hot_i, cold_i, lim1, lim2, lim3, lim4, delta_temp_o;
	logic [TCF_NUM_ALERTS-1:0] alert_src_cold_i;
	logic [2:0] tc_type_o;
	int fails, samples_checked;

	tcf_host host (.clk_i(clk_i), .cfg_wr_o(cfg_wr_i), .cfg_wdata_o(cfg_wdata_i));
	tcf_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i),
		.cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
		.status_alert_o(status_alert_o), .hot_vld_i(hot_vld_i), .hot_i(hot_i),
		.cold_i(cold_i), .first_alert_limit_i(lim1), .second_alert_limit_i(lim2),
		.third_alert_limit_i(lim3), .fourth_alert_limit_i(lim4),
		.alert_src_cold_i(alert_src_cold_i), .delta_temp_o(delta_temp_o),
		.tc_type_o(tc_type_o), .corr_coef_set_o(corr_coef_set_o));

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic close_out;
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	task automatic send_hot(input logic signed [15:0] x);
		@(negedge clk_i);
		hot_i = x;
		hot_vld_i = 1'b1;
		@(negedge clk_i);
		hot_vld_i = 1'b0;
		// Result lands one rising edge after the sample edge
		@(negedge clk_i);
		@(negedge clk_i);
	endtask : send_hot

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic test_reset;
		check(cfg_rdata_o, 8'h00, "cfg after reset");
		check(tc_type_o, 3'h0, "type after reset");
		check(corr_coef_set_o, 8'h01, "coef after reset");
		check(status_alert_o, 8'h00, "status after reset");
		check(delta_temp_o, 16'h0000, "delta after reset");
	endtask : test_reset

	task automatic test_types;
		for (int c = 0; c < 8; c++) begin
			d = {1'b1, c[2:0], 1'b1, 3'h5};
			host.write_cfg(d);
			check(cfg_rdata_o, d & 8'h77, "cfg readback");
			check(tc_type_o, c[2:0], "type code");
			check(corr_coef_set_o, 8'h01 << c, "coef set");
		end
	endtask : test_types

	task automatic test_alerts;
		host.write_cfg(8'h00);
		alert_src_cold_i = 4'h5;
		cold_i = 16'sd50;
		lim1 = 16'sd49;
		lim2 = 16'sd100;
		lim3 = 16'sd50;
		lim4 = 16'sd101;
		send_hot(16'sd101);
		check(delta_temp_o, 16'sd101, "raw pass");
		check(status_alert_o, 8'h03, "equal limits");
		send_hot(16'sd102);
		check(status_alert_o, 8'h0B, "fourth alert");
	endtask : test_alerts

	task automatic test_filter;
		host.write_cfg(8'h01);
		alert_src_cold_i = 4'h0;
		lim1 = 16'sd199;
		lim2 = 16'sd200;
		lim3 = 16'sd299;
		lim4 = -16'sd5;
		send_hot(16'sd0);
		check(delta_temp_o, 16'sd0, "first raw");
		send_hot(16'sd300);
		check(delta_temp_o, 16'sd200, "step n1");
		check(status_alert_o, 8'h09, "filtered alerts");
		send_hot(16'sd300);
		check(delta_temp_o, 16'sd266, "second step");
		host.write_cfg(8'h01);
		// Sample raised in the clear cycle must be refused
		hot_i = 16'sd77;
		hot_vld_i = 1'b1;
		@(negedge clk_i);
		hot_vld_i = 1'b0;
		repeat (2) @(negedge clk_i);
		check(delta_temp_o, 16'sd266, "sample in clear cycle");
		send_hot(-16'sd40);
		check(delta_temp_o, -16'sd40, "history cleared");
		host.write_cfg(8'h07);
		send_hot(16'sd0);
		send_hot(16'sd129);
		check(delta_temp_o, 16'sd2, "max filter step");
	endtask : test_filter

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	initial begin
		// Run needs under a hundred cycles; 5000 cycles is ample
		#(50 * 5000);
		fails++;
		close_out();
	end

	initial begin
		rst_n_i = 1'b0;
		hot_vld_i = 1'b0;
		hot_i = 16'sd0;
		cold_i = 16'sd0;
		lim1 = 16'sd0;
		lim2 = 16'sd0;
		lim3 = 16'sd0;
		lim4 = 16'sd0;
		alert_src_cold_i = 4'h0;
		fails = 0;
		samples_checked = 0;
		repeat (20) @(negedge clk_i);
		test_reset();
		rst_n_i = 1'b1;
		test_types();
		test_alerts();
		test_filter();
		close_out();
	end
endmodule : tb
`default_nettype wire
